// File: logic/ulf_pkg.sv
/*
 * package for the uart line format control block: register offsets,
 * field positions, reset values, tick counts, state codes and the
 * format decoding shared by transmit and receive.
 * assumes a 32-bit apb with byte addresses and one word per register.
 */
`default_nettype none

package ulf_pkg;

   // =========================================================
   // register map (byte addresses)
   localparam logic [7:0] OFF_DATA = 8'h00;
   localparam logic [7:0] OFF_LFC = 8'h04;
   localparam logic [7:0] OFF_MIC = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0C;
   localparam logic [7:0] OFF_DIVLO = 8'h10;
   localparam logic [7:0] OFF_DIVHI = 8'h14;
   localparam logic [7:0] OFF_EFM = 8'h18;

   // =========================================================
   // reset values
   localparam logic [7:0] LFC_RST = 8'h00;
   localparam logic [7:0] MIC_RST = 8'h00;
   localparam logic [7:0] DIV_RST = 8'h00;
   localparam logic [7:0] EFM_RST = 8'h00;

   // =========================================================
   // line_format_control fields
   localparam int DIVISOR_ACCESS_BIT = 7;
   localparam int LINE_BREAK_BIT = 6;
   localparam int PARITY_SELECT_HI = 5;
   localparam int PARITY_SELECT_LO = 3;
   localparam int STOP_LENGTH_BIT = 2;
   localparam int WORD_LENGTH_HI = 1;
   localparam int WORD_LENGTH_LO = 0;

   // modem_interface_control fields
   localparam int CLOCK_PRESCALE_SELECT = 7;
   localparam int INFRARED_ROUTE_ENABLE = 6;

   // status register fields
   localparam int ST_RX_READY = 0;
   localparam int ST_OVERRUN = 1;
   localparam int ST_PARITY_ERR = 2;
   localparam int ST_FRAMING_ERR = 3;
   localparam int ST_HOLD_EMPTY = 4;
   localparam int ST_TX_IDLE = 5;

   // =========================================================
   // timing counts: prescale in clocks, the rest in 16x ticks
   localparam logic [1:0] PRESCALE_LAST = 2'h3;
   localparam logic [3:0] BIT_LAST = 4'hF;
   localparam logic [3:0] HALF_BIT_LAST = 4'h7;
   localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
   localparam logic [4:0] IR_HOLD_TICKS = 5'h10;
   localparam logic [4:0] STOP1_LAST = 5'h0F;
   localparam logic [4:0] STOP15_LAST = 5'h17;
   localparam logic [4:0] STOP2_LAST = 5'h1F;

   // =========================================================
   // state codes
   typedef enum logic [4:0] {
      TX_IDLE = 5'h01,
      TX_START = 5'h02,
      TX_DATA = 5'h04,
      TX_PAR = 5'h08,
      TX_STOP = 5'h10
   } ulf_tx_state_t;

   typedef enum logic [4:0] {
      RX_IDLE = 5'h01,
      RX_START = 5'h02,
      RX_DATA = 5'h04,
      RX_PAR = 5'h08,
      RX_STOP = 5'h10
   } ulf_rx_state_t;

   // =========================================================
   // format decoding
   // number of data bits, 5 to 8
   function automatic logic [3:0] ulf_word_bits(input logic [1:0] wl);
      return 4'h5 + {2'h0, wl};
   endfunction : ulf_word_bits

   // mask of the data bits in use
   function automatic logic [7:0] ulf_word_mask(input logic [1:0] wl);
      return 8'hFF >> (3'h3 - {1'h0, wl});
   endfunction : ulf_word_mask

   // last tick index of the stop period
   function automatic logic [4:0] ulf_stop_last(input logic stop, input logic [1:0] wl);
      if (!stop) begin
         return STOP1_LAST;
      end
      if (wl == 2'h0) begin
         return STOP15_LAST;
      end
      return STOP2_LAST;
   endfunction : ulf_stop_last

   // parity bit for masked data: odd, even, forced one, forced zero
   function automatic logic ulf_parity(input logic [7:0] d, input logic [1:0] mode);
      case (mode)
         2'h0: return ~(^d);
         2'h1: return ^d;
         2'h2: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : ulf_parity

endpackage : ulf_pkg

`default_nettype wire

// File: logic/ulf_baud_gen.sv
/*
 * baud tick generator: optional divide by 4 prescale, then the
 * 16-bit divisor, giving a one-cycle 16x oversampling tick.
 * assumes one clock; a divisor of zero acts as one.
 */
`timescale 1ns/1ns
`default_nettype none

module ulf_baud_gen
   import ulf_pkg::*;
(
   input wire logic clock_i,          // system clock
   input wire logic rst_n_i,          // async reset, active low
   input wire logic prescale_sel_i,   // 1 divides clock by 4
   input wire logic [15:0] divisor_i, // baud divisor
   output logic tick_o                // 16x tick, one cycle
);

   // =========================================================
   // prescale and divisor
   logic [1:0] pre_cnt_r;
   logic [15:0] div_cnt_r;
   logic tick_r;
   wire pre_en = prescale_sel_i ? (pre_cnt_r == PRESCALE_LAST) : 1'b1;
   wire [15:0] div_last = (divisor_i == 16'h0000) ? 16'h0000 : divisor_i - 16'h0001;
   wire div_wrap = pre_en && (div_cnt_r >= div_last);

   // counters run free; tick at each divisor wrap
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_cnt_r <= 2'h0;
         div_cnt_r <= 16'h0000;
         tick_r <= 1'b0;
      end else begin
         pre_cnt_r <= pre_cnt_r + 2'h1;
         if (pre_en) begin
            div_cnt_r <= div_wrap ? 16'h0000 : div_cnt_r + 16'h0001;
         end
         tick_r <= div_wrap;
      end
   end

   assign tick_o = tick_r;

endmodule : ulf_baud_gen

`default_nettype wire

// File: logic/ulf_line_format.sv
/*
 * uart line format control: apb register file, character framing
 * for transmit and receive, line break, clock prescale and the
 * infrared encoder and decoder.
 * assumes apb signals and serial inputs synchronous to clock_i.
 */
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - divisor-access bit exposes divisor and enhanced registers
// - break bit holds serial output low outside infrared mode (tx_o stays high while infrared is on)
// - parity: off, odd, even, forced one, forced zero
// - stop bits: one, one and half, two
// - word length five to eight bits
// - reset clears all line format bits
// - prescale select divides clock by four
// - infrared bit routes serial through encoder, decoder
// - infrared output low while idle
module ulf_line_format
   import ulf_pkg::*;
(
   input wire logic clock_i,          // system clock, 125 MHz
   input wire logic rst_n_i,          // async reset, active low
   input wire logic psel_i,           // apb select
   input wire logic penable_i,        // apb enable
   input wire logic pwrite_i,         // apb direction
   input wire logic [7:0] paddr_i,    // apb byte address
   input wire logic [31:0] pwdata_i,  // apb write data
   output logic [31:0] prdata_o,      // apb read data
   output logic pready_o,             // apb ready
   output logic pslverr_o,            // apb error
   output logic tx_o,                 // serial transmit
   input wire logic rx_i,             // serial receive
   output logic ir_tx_o,              // infrared transmit
   input wire logic ir_rx_i           // infrared receive pulse
);

   // =========================================================
   // registers
   logic [7:0] lfc_r;
   logic [7:0] mic_r;
   logic [7:0] div_lo_r;
   logic [7:0] div_hi_r;
   logic [7:0] efm_r;
   logic [31:0] prdata_r;
   logic [7:0] hold_r;
   logic hold_full_r;
   logic [7:0] rx_data_r;
   logic rx_ready_r;
   logic overrun_r;
   logic par_err_r;
   logic frame_err_r;

   // format fields
   wire dab = lfc_r[DIVISOR_ACCESS_BIT];
   wire brk = lfc_r[LINE_BREAK_BIT];
   wire [2:0] psf = lfc_r[PARITY_SELECT_HI:PARITY_SELECT_LO];
   wire par_en = psf[0];
   wire [1:0] par_mode = psf[2:1];
   wire stop_len = lfc_r[STOP_LENGTH_BIT];
   wire [1:0] wl = lfc_r[WORD_LENGTH_HI:WORD_LENGTH_LO];
   wire ir_en = mic_r[INFRARED_ROUTE_ENABLE];
   wire [3:0] nbits = ulf_word_bits(wl);
   wire [4:0] stop_last = ulf_stop_last(stop_len, wl);

   // =========================================================
   // apb decode
   wire setup = psel_i && !penable_i;
   wire acc = psel_i && penable_i;
   wire hit_data = (paddr_i == OFF_DATA);
   wire hit_lfc = (paddr_i == OFF_LFC);
   wire hit_mic = (paddr_i == OFF_MIC);
   wire hit_stat = (paddr_i == OFF_STAT);
   wire hit_dlo = (paddr_i == OFF_DIVLO);
   wire hit_dhi = (paddr_i == OFF_DIVHI);
   wire hit_efm = (paddr_i == OFF_EFM);
   wire hidden_ok = dab;
   wire mapped = hit_data || hit_lfc || hit_mic || hit_stat
              || ((hit_dlo || hit_dhi || hit_efm) && hidden_ok);
   wire wr = acc && pwrite_i && mapped;
   wire rd = acc && !pwrite_i && mapped;
   wire wr_data = wr && hit_data;
   wire rd_data = rd && hit_data;
   wire rd_stat = rd && hit_stat;

   // status word
   logic tx_idle;
   wire [7:0] stat = {2'h0, tx_idle, !hold_full_r, frame_err_r,
                      par_err_r, overrun_r, rx_ready_r};

   // read mux; hidden registers read as zero
   wire [7:0] rd_mux =
      hit_data ? rx_data_r :
      hit_lfc ? lfc_r :
      hit_mic ? mic_r :
      hit_stat ? stat :
      (hit_dlo && hidden_ok) ? div_lo_r :
      (hit_dhi && hidden_ok) ? div_hi_r :
      (hit_efm && hidden_ok) ? efm_r : 8'h00;

   assign pready_o = 1'b1;
   assign pslverr_o = acc && !mapped;
   assign prdata_o = prdata_r;

   // configuration writes in access phase; read data capture in setup phase
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lfc_r <= LFC_RST;
         mic_r <= MIC_RST;
         div_lo_r <= DIV_RST;
         div_hi_r <= DIV_RST;
         efm_r <= EFM_RST;
         prdata_r <= 32'h00000000;
      end else begin
         if (setup) begin
            prdata_r <= {24'h000000, rd_mux};
         end
         if (wr && hit_lfc) begin
            lfc_r <= pwdata_i[7:0];
         end
         if (wr && hit_mic) begin
            mic_r <= pwdata_i[7:0];
         end
         if (wr && hit_dlo) begin
            div_lo_r <= pwdata_i[7:0];
         end
         if (wr && hit_dhi) begin
            div_hi_r <= pwdata_i[7:0];
         end
         if (wr && hit_efm) begin
            efm_r <= pwdata_i[7:0];
         end
      end
   end

   // =========================================================
   // baud tick
   logic tick;

   ulf_baud_gen u_baud (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .prescale_sel_i(mic_r[CLOCK_PRESCALE_SELECT]),
      .divisor_i({div_hi_r, div_lo_r}),
      .tick_o(tick)
   );

   // =========================================================
   // transmitter
   ulf_tx_state_t tx_st_r, tx_st_nxt;
   logic [4:0] tx_cnt_r;
   logic [2:0] tx_bit_r;
   logic [7:0] tx_sh_r;
   logic tx_par_r;
   logic tx_bit;

   wire tx_take = (tx_st_r == TX_IDLE) && hold_full_r;
   wire tx_bit_end = tick && (tx_cnt_r[3:0] == BIT_LAST);
   wire tx_last_data = ({1'h0, tx_bit_r} == nbits - 4'h1);
   wire tx_stop_end = tick && (tx_cnt_r == stop_last);
   wire [7:0] hold_masked = hold_r & ulf_word_mask(wl);

   // next state of the framing sequence
   always_comb begin
      tx_st_nxt = tx_st_r;
      case (tx_st_r)
         TX_IDLE: begin
            if (tx_take) tx_st_nxt = TX_START;
         end
         TX_START: begin
            if (tx_bit_end) tx_st_nxt = TX_DATA;
         end
         TX_DATA: begin
            if (tx_bit_end && tx_last_data) begin
               tx_st_nxt = par_en ? TX_PAR : TX_STOP;
            end
         end
         TX_PAR: begin
            if (tx_bit_end) tx_st_nxt = TX_STOP;
         end
         TX_STOP: begin
            if (tx_stop_end) tx_st_nxt = TX_IDLE;
         end
         default: tx_st_nxt = TX_IDLE;
      endcase
   end

   // line level of the current bit
   always_comb begin
      case (tx_st_r)
         TX_START: tx_bit = 1'b0;
         TX_DATA: tx_bit = tx_sh_r[tx_bit_r];
         TX_PAR: tx_bit = tx_par_r;
         default: tx_bit = 1'b1;
      endcase
   end

   assign tx_idle = (tx_st_r == TX_IDLE);

   // bit timing, shift data and holding register
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_st_r <= TX_IDLE;
         tx_cnt_r <= 5'h00;
         tx_bit_r <= 3'h0;
         tx_sh_r <= 8'h00;
         tx_par_r <= 1'b0;
         hold_r <= 8'h00;
         hold_full_r <= 1'b0;
      end else begin
         tx_st_r <= tx_st_nxt;
         if (tx_take) begin
            tx_sh_r <= hold_masked;
            tx_par_r <= ulf_parity(hold_masked, par_mode);
            tx_cnt_r <= 5'h00;
            tx_bit_r <= 3'h0;
         end else if (tx_bit_end && (tx_st_r != TX_STOP)) begin
            tx_cnt_r <= 5'h00;
            if (tx_st_r == TX_DATA) tx_bit_r <= tx_bit_r + 3'h1;
         end else if (tick) begin
            tx_cnt_r <= tx_cnt_r + 5'h01;
         end
         // a write while the holding register is full is dropped
         if (wr_data && !hold_full_r) begin
            hold_r <= pwdata_i[7:0];
            hold_full_r <= 1'b1;
         end else if (tx_take) begin
            hold_full_r <= 1'b0;
         end
      end
   end

   // =========================================================
   // infrared encoder and output pins
   logic [3:0] ir_ph_r;
   logic ir_tx_r;
   logic tx_r;
   wire line_out = brk ? 1'b0 : tx_bit;

   // pulse in the first ticks of each low bit; idle stays low
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ir_ph_r <= 4'h0;
         ir_tx_r <= 1'b0;
         tx_r <= 1'b1;
      end else begin
         if (tx_take) begin
            ir_ph_r <= 4'h0;
         end else if (tick) begin
            ir_ph_r <= ir_ph_r + 4'h1;
         end
         ir_tx_r <= ir_en && !line_out && (ir_ph_r < IR_PULSE_TICKS);
         tx_r <= ir_en ? 1'b1 : line_out;
      end
   end

   assign tx_o = tx_r;
   assign ir_tx_o = ir_tx_r;

   // =========================================================
   // infrared decoder: each pulse marks one low bit time
   logic [4:0] ir_hold_r;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ir_hold_r <= 5'h00;
      end else if (ir_rx_i) begin
         ir_hold_r <= IR_HOLD_TICKS;
      end else if (tick && (ir_hold_r != 5'h00)) begin
         ir_hold_r <= ir_hold_r - 5'h01;
      end
   end

   wire ir_line = (ir_hold_r == 5'h00);
   wire rx_line = ir_en ? ir_line : rx_i;

   // =========================================================
   // receiver
   ulf_rx_state_t rx_st_r, rx_st_nxt;
   logic [3:0] rx_cnt_r;
   logic [2:0] rx_bit_r;
   logic [7:0] rx_sh_r;
   logic rx_par_bad_r;

   wire rx_mid = tick && (rx_cnt_r == BIT_LAST);
   wire rx_half = tick && (rx_cnt_r == HALF_BIT_LAST);
   wire rx_last_data = ({1'h0, rx_bit_r} == nbits - 4'h1);
   wire rx_done = rx_mid && (rx_st_r == RX_STOP);
   wire rx_par_exp = ulf_parity(rx_sh_r, par_mode);

   // next state of the character assembly
   always_comb begin
      rx_st_nxt = rx_st_r;
      case (rx_st_r)
         RX_IDLE: begin
            if (!rx_line) rx_st_nxt = RX_START;
         end
         RX_START: begin
            if (rx_half) rx_st_nxt = rx_line ? RX_IDLE : RX_DATA;
         end
         RX_DATA: begin
            if (rx_mid && rx_last_data) begin
               rx_st_nxt = par_en ? RX_PAR : RX_STOP;
            end
         end
         RX_PAR: begin
            if (rx_mid) rx_st_nxt = RX_STOP;
         end
         RX_STOP: begin
            if (rx_mid) rx_st_nxt = RX_IDLE;
         end
         default: rx_st_nxt = RX_IDLE;
      endcase
   end

   // sampling at mid bit
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_st_r <= RX_IDLE;
         rx_cnt_r <= 4'h0;
         rx_bit_r <= 3'h0;
         rx_sh_r <= 8'h00;
         rx_par_bad_r <= 1'b0;
      end else begin
         rx_st_r <= rx_st_nxt;
         if (rx_st_r == RX_IDLE) begin
            rx_cnt_r <= 4'h0;
            rx_bit_r <= 3'h0;
            rx_sh_r <= 8'h00;
            rx_par_bad_r <= 1'b0;
         end else if (rx_half && (rx_st_r == RX_START)) begin
            rx_cnt_r <= 4'h0;
         end else if (tick) begin
            rx_cnt_r <= rx_cnt_r + 4'h1;
         end
         if (rx_mid && (rx_st_r == RX_DATA)) begin
            rx_sh_r[rx_bit_r] <= rx_line;
            rx_bit_r <= rx_bit_r + 3'h1;
         end
         if (rx_mid && (rx_st_r == RX_PAR)) begin
            rx_par_bad_r <= (rx_line != rx_par_exp);
         end
      end
   end

   // =========================================================
   // receive data and sticky status; a new event wins over a clear
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_data_r <= 8'h00;
         rx_ready_r <= 1'b0;
         overrun_r <= 1'b0;
         par_err_r <= 1'b0;
         frame_err_r <= 1'b0;
      end else begin
         if (rx_done) begin
            rx_data_r <= rx_sh_r;
         end
         if (rx_done) begin
            rx_ready_r <= 1'b1;
         end else if (rd_data) begin
            rx_ready_r <= 1'b0;
         end
         if (rx_done && rx_ready_r && !rd_data) begin
            overrun_r <= 1'b1;
         end else if (rd_stat) begin
            overrun_r <= 1'b0;
         end
         if (rx_done && rx_par_bad_r) begin
            par_err_r <= 1'b1;
         end else if (rd_stat) begin
            par_err_r <= 1'b0;
         end
         if (rx_done && !rx_line) begin
            frame_err_r <= 1'b1;
         end else if (rd_stat) begin
            frame_err_r <= 1'b0;
         end
      end
   end

endmodule : ulf_line_format

`default_nettype wire

// File: tb/ulf_monitor.sv
/* checker for ulf_line_format, sees only its ports.
   assumes divisor at most 1 and no prescale while infrared pulses go out. */
`timescale 1ns/1ns
`default_nettype none
module ulf_monitor
   import ulf_pkg::*;
(
   input wire logic clock_i, // clock
   input wire logic rst_n_i, // reset, low
   input wire logic psel_i, // select
   input wire logic penable_i, // enable
   input wire logic pwrite_i, // write
   input wire logic [7:0] paddr_i, // address
   input wire logic [31:0] pwdata_i, // write data
   input wire logic [31:0] prdata_o, // read data
   input wire logic pready_o, // ready
   input wire logic pslverr_o, // error
   input wire logic tx_o, // serial out
   input wire logic rx_i, // serial in
   input wire logic ir_tx_o, // ir out
   input wire logic ir_rx_i // ir in
);
   // ====================
   // shadow registers
   logic [7:0] lfc_r;
   logic [7:0] mic_r;
   wire logic acc = psel_i && penable_i;
   wire logic hid = paddr_i inside {OFF_DIVLO, OFF_DIVHI, OFF_EFM};
   // follow host writes to the two format registers
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lfc_r <= 8'h00;
         mic_r <= 8'h00;
      end else begin
         lfc_r <= (acc && pwrite_i && paddr_i == OFF_LFC) ? pwdata_i[7:0] : lfc_r;
         mic_r <= (acc && pwrite_i && paddr_i == OFF_MIC) ? pwdata_i[7:0] : mic_r;
      end
   end
   // ====================
   // properties
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   ready_now_a: assert property (acc |-> pready_o) else $error("no ready in access");
   hidden_err_a: assert property (acc && hid && !lfc_r[7] |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
      else $error("hidden register reachable");
   open_ok_a: assert property (acc && hid && lfc_r[7] |-> !pslverr_o)
      else $error("open register refused");
   lfc_read_a: assert property (acc && !pwrite_i && paddr_i == OFF_LFC |-> prdata_o == {24'h0, lfc_r})
      else $error("line format readback wrong");
   mic_read_a: assert property (acc && !pwrite_i && paddr_i == OFF_MIC |-> prdata_o == {24'h0, mic_r})
      else $error("modem control readback wrong");
   break_low_a: assert property ((lfc_r[LINE_BREAK_BIT] && !mic_r[6]) [*2] |-> !tx_o)
      else $error("break not low");
   ir_tx_high_a: assert property (mic_r[6] [*2] |-> tx_o)
      else $error("plain output active in infrared mode");
   plain_ir_low_a: assert property (!mic_r[6] [*2] |-> !ir_tx_o)
      else $error("infrared output active in plain mode");
   ir_pulse_a: assert property ($rose(ir_tx_o) && !mic_r[7] |-> ir_tx_o [*3] ##1 !ir_tx_o)
      else $error("infrared pulse width wrong");
   // main scenarios seen
   break_c: cover property (lfc_r[6] && !tx_o);
   ir_c: cover property ($rose(ir_tx_o));
   hidden_c: cover property (acc && hid && pslverr_o);
endmodule : ulf_monitor
bind ulf_line_format ulf_monitor i_mon (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_o(tx_o),
   .rx_i(rx_i), .ir_tx_o(ir_tx_o), .ir_rx_i(ir_rx_i));
`default_nettype wire

// File: tb/ulf_remote_peer.sv
/* remote serial peer: sends characters on the plain or infrared line.
   assumes 16 clocks a bit time. */
`timescale 1ns/1ns
`default_nettype none
module ulf_remote_peer (
   input wire logic clock_i, // clock
   output logic line_o, // plain line, idle high
   output logic ir_o // ir pulses, idle low
);
   // idle levels
   initial begin
      line_o = 1'b1;
      ir_o = 1'b0;
   end
   // one bit time; a zero is a short pulse on the ir line
   task automatic put(input logic b, input logic ir);
      for (int k = 0; k < 16; k++) begin
         line_o <= ir | b;
         ir_o <= ir & !b & (k < 3);
         @(posedge clock_i);
      end
   endtask : put
   // one whole character in the agreed format
   task automatic send(input logic [7:0] d, input int nb, input logic pen, input logic p,
      input logic stop2, input logic ir);
      put(1'b0, ir);
      for (int i = 0; i < nb; i++) put(d[i], ir);
      if (pen) put(p, ir);
      put(1'b1, ir);
      if (stop2) put(1'b1, ir);
   endtask : send
endmodule : ulf_remote_peer
`default_nettype wire

// File: tb/tb_ulf_line_format.sv
/* testbench for ulf_line_format: registers, transmit framing, break,
   prescale, infrared and receive. assumes divisor 1: 16 clocks a bit. */
`timescale 1ns/1ns
`default_nettype none
module tb_ulf_line_format
   import ulf_pkg::*;
;
   logic clock_i, rst_n_i, psel_i, penable_i, pwrite_i, rx_i, ir_rx_i, er, st, p, q;
   logic [7:0] paddr_i, v, d;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic pready_o, pslverr_o, tx_o, ir_tx_o;
   logic [1:0] wl;
   logic [2:0] pf;
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0;
   int t0, n;
   // ====================
   // design and peer
   ulf_line_format i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_o(tx_o),
      .rx_i(rx_i), .ir_tx_o(ir_tx_o), .ir_rx_i(ir_rx_i));
   ulf_remote_peer i_peer (.clock_i(clock_i), .line_o(rx_i), .ir_o(ir_rx_i));
   // clock and cycle count
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   always @(posedge clock_i) cyc <= cyc + 1;
   // ====================
   // helpers
   function automatic logic [7:0] kept(input logic [7:0] x, input logic [1:0] w);
      return x & ~(8'hFF << (int'(w) + 5));
   endfunction : kept
   function automatic logic par_of(input logic [7:0] x, input logic [1:0] m);
      case (m)
         2'h0: return ~(^x);
         2'h1: return ^x;
         2'h2: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : par_of
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer, waits for ready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clock_i);
         k++;
      end while (pready_o !== 1'b1 && k < 20);
      rd = prdata_o;
      er = pslverr_o;
      chk({31'h0, pready_o}, 32'h1);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clock_i);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      apb(1'b1, a, {24'h0, x});
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic ee);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({31'h0, er}, {31'h0, ee});
   endtask : rdc
   task automatic at(input int t);
      while (cyc < t) begin
         @(posedge clock_i);
         #1;
      end
   endtask : at
   task automatic fall(output int t);
      int k;
      k = 0;
      while (tx_o !== 1'b0 && k < 3000) begin
         @(posedge clock_i);
         #1;
         k++;
      end
      chk({31'h0, tx_o}, 32'h0);
      t = cyc;
   endtask : fall
   // two characters back to back; bits and spacing checked
   task automatic tx_case(input logic [1:0] w, input logic s, input logic [2:0] f);
      int nb, len, t, t1;
      logic [7:0] x;
      x = 8'($urandom);
      nb = int'(w) + 5;
      len = 16 * (nb + 1 + int'(f[0])) + (s ? (w == 2'h0 ? 24 : 32) : 16);
      wr(OFF_LFC, {2'h0, f, s, w});
      wr(OFF_DATA, x);
      fall(t);
      wr(OFF_DATA, ~x);
      for (int i = 1; i <= nb; i++) begin
         at(t + 8 + 16 * i);
         chk({31'h0, tx_o}, {31'h0, x[i-1]});
      end
      at(t + 8 + 16 * (nb + 1));
      if (f[0]) chk({31'h0, tx_o}, {31'h0, par_of(kept(x, w), f[2:1])});
      at(t + 8 + 16 * (nb + 1 + int'(f[0])));
      chk({31'h0, tx_o}, 32'h1);
      fall(t1);
      chk({31'h0, t1 - t >= len - 2 && t1 - t <= len + 2}, 32'h1);
      at(t1 + len + 16);
   endtask : tx_case
   task automatic give_verdict();
      $display("checks %0d bad %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict
   // ====================
   // watchdog
   initial begin
      #(8 * 60000);
      bad_count++;
      give_verdict();
   end
   // main sequence
   initial begin
      rst_n_i = 1'b0;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0;
      void'($urandom(25635));
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      rdc(OFF_LFC, 32'h0, 1'b0);
      rdc(OFF_MIC, 32'h0, 1'b0);
      rdc(OFF_DIVLO, 32'h0, 1'b1);
      wr(OFF_EFM, 8'h5A);
      rdc(8'h1C, 32'h0, 1'b1);
      v = {2'h2, 6'($urandom)};
      wr(OFF_LFC, v);
      rdc(OFF_LFC, {24'h0, v}, 1'b0);
      rdc(OFF_EFM, 32'h0, 1'b0);
      wr(OFF_DIVLO, 8'h01);
      wr(OFF_DIVHI, 8'h00);
      rdc(OFF_DIVLO, 32'h1, 1'b0);
      v = {2'h0, 6'($urandom)};
      wr(OFF_MIC, v);
      rdc(OFF_MIC, {24'h0, v}, 1'b0);
      wr(OFF_MIC, 8'h00);
      wr(OFF_LFC, 8'h00);
      rdc(OFF_DIVHI, 32'h0, 1'b1);
      $display("test registers done");
      for (int i = 0; i < 40; i++) begin
         pf = (i < 8) ? {2'($urandom), 1'b0} : {2'(i / 8 - 1), 1'b1};
         tx_case(2'(i % 4), 1'(i / 4 % 2), pf);
      end
      $display("test transmit done");
      wr(OFF_LFC, 8'h43);
      repeat (20) @(posedge clock_i);
      chk({31'h0, tx_o}, 32'h0);
      wr(OFF_DATA, 8'hFF);
      repeat (300) @(posedge clock_i);
      chk({31'h0, tx_o}, 32'h0);
      wr(OFF_LFC, 8'h03);
      repeat (3) @(posedge clock_i);
      chk({31'h0, tx_o}, 32'h1);
      $display("test break done");
      wr(OFF_MIC, 8'h80);
      wr(OFF_DATA, 8'hFF);
      fall(t0);
      at(t0 + 30);
      while (tx_o === 1'b0 && cyc < t0 + 100) at(cyc + 1);
      chk({31'h0, cyc - t0 >= 60 && cyc - t0 <= 66}, 32'h1);
      at(t0 + 64 * 11);
      wr(OFF_MIC, 8'h00);
      $display("test prescale done");
      for (int k = 0; k < 9; k++) begin
         wl = 2'($urandom);
         st = 1'($urandom);
         pf = (k == 8) ? {2'($urandom), 1'b1} : 3'($urandom);
         d = 8'($urandom);
         p = par_of(kept(d, wl), pf[2:1]) ^ (k == 8);
         wr(OFF_LFC, {2'h0, pf, st, wl});
         i_peer.send(d, int'(wl) + 5, pf[0], p, st, 1'b0);
         repeat (4) @(posedge clock_i);
         rdc(OFF_STAT, {26'h0, 2'h3, 1'b0, k == 8, 1'b0, 1'b1}, 1'b0);
         rdc(OFF_DATA, {24'h0, kept(d, wl)}, 1'b0);
      end
      $display("test receive done");
      wr(OFF_LFC, 8'h03);
      wr(OFF_MIC, 8'h40);
      repeat (3) @(posedge clock_i);
      chk({31'h0, ir_tx_o}, 32'h0);
      chk({31'h0, tx_o}, 32'h1);
      d = 8'($urandom);
      wr(OFF_DATA, d);
      n = 0;
      q = 1'b0;
      repeat (200) begin
         at(cyc + 1);
         n += int'(ir_tx_o === 1'b1 && q === 1'b0);
         q = ir_tx_o;
      end
      chk(n, 9 - $countones(d));
      d = 8'($urandom);
      i_peer.send(d, 8, 1'b0, 1'b0, 1'b0, 1'b1);
      repeat (4) @(posedge clock_i);
      rdc(OFF_DATA, {24'h0, d}, 1'b0);
      wr(OFF_MIC, 8'h00);
      $display("test infrared done");
      give_verdict();
   end
endmodule : tb_ulf_line_format
`default_nettype wire
